// File: src/cdms_defs.svh
// Constants for the channel data mux slice
`ifndef CDMS_DEFS_SVH
`define CDMS_DEFS_SVH
`define CDMS_DATA_W        5
`define CDMS_NUM_CH        3
`define CDMS_NUM_BRL       2
`define CDMS_MUX_RST       5'h00
`define CDMS_CLK_PERIOD_NS 10
`define CDMS_PHASE_NS      50
`define CDMS_PHASE_CYC     ((`CDMS_PHASE_NS) / (`CDMS_CLK_PERIOD_NS))
`define CDMS_FIFO_DEPTH    4
`define CDMS_SHIFT_BITS    4
`endif

// File: src/cdms_pkg.sv
// Types for the channel data mux slice
`include "cdms_defs.svh"
package cdms_pkg;
  typedef logic [`CDMS_DATA_W-1:0] cdms_word_t;
  typedef enum logic {CDMS_MODE_LEVEL, CDMS_MODE_LEGACY} cdms_mode_e;
  typedef struct packed {
    logic [`CDMS_NUM_CH-1:0] fof;
    logic [`CDMS_NUM_CH-1:0] sel;
    logic [`CDMS_NUM_CH-1:0] empty;
    cdms_word_t              data;
  } cdms_barrel_s;
  typedef struct packed {
    logic       active;
    logic       full;
    logic       flag;
    logic       error;
  } cdms_ctl_s;
endpackage : cdms_pkg

// File: src/cdms_fifo.sv
// Small valid/ready FIFO for external input words
`timescale 1ns/1ps
module cdms_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_sys_rst,
  // Fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // Drain side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire              push = i_in_valid && o_in_ready;
  wire              pop  = o_out_valid && i_out_ready;

  assign o_in_ready  = (count != (AW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data  = mem[rd_ptr];

  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + AW'(1);
      if (pop)  rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + AW'(1);
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  fifo_bound_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    count <= (AW+1)'(DEPTH)) else $error("FIFO count over depth");
endmodule : cdms_fifo

// File: src/cdms_slice.sv
// Channel data mux slice: three mux registers shared by two barrels
`timescale 1ns/1ps
`include "cdms_defs.svh"
module cdms_slice
  import cdms_pkg::*;
(
  // Clock and reset
  input  wire logic                      i_core_clk,
  input  wire logic                      i_sys_rst,
  // Delayed master clear, active low
  input  wire logic                      i_master_clear_delayed_n,
  // Barrel ports
  input  wire cdms_barrel_s              i_barrel0,
  input  wire cdms_barrel_s              i_barrel1,
  output cdms_word_t                     o_barrel0_data,
  output cdms_word_t                     o_barrel1_data,
  // External channels 0 and 1
  input  wire logic [1:0]                i_chan_load_n,
  input  wire cdms_word_t                i_ext_data0,
  input  wire cdms_word_t                i_ext_data1,
  input  wire logic                      i_ext_valid1,
  output logic                           o_ext_ready1,
  output cdms_word_t                     o_ext_out0,
  output cdms_word_t                     o_ext_out1,
  output logic                           o_buffer_odd_parity,
  output logic [`CDMS_NUM_CH-1:0]        o_mux_register_odd_parity,
  output logic [1:0]                     o_chan_legacy,
  // Strobe phases
  output logic                           o_base_clock_phase,
  output logic                           o_strobe_phase_a,
  output logic                           o_strobe_phase_b,
  output logic                           o_strobe_phase_c,
  output logic                           o_strobe_phase_d,
  // Maintenance serial access
  input  wire cdms_ctl_s [`CDMS_NUM_CH-1:0] i_chan_ctl,
  input  wire logic [1:0]                i_mac_addr,
  input  wire logic                      i_mac_load,
  output logic                           o_mac_serial_data
);
  localparam int PC = `CDMS_PHASE_CYC;
  localparam int PW = $clog2(PC);

  // Phase divider: one base phase pulse every 50 ns
  logic [PW-1:0] div_cnt;
  logic [1:0]    slot_ph;
  logic          mcd_q;
  wire           mcd_rise = i_master_clear_delayed_n && !mcd_q;
  wire           base_tick = (div_cnt == PW'(PC-1));
  wire           mc_active = !i_master_clear_delayed_n;

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mcd_q   <= 1'b1;
      div_cnt <= '0;
      slot_ph <= '0;
    end else begin
      mcd_q <= i_master_clear_delayed_n;
      if (mcd_rise) begin
        div_cnt <= '0;
        slot_ph <= '0;
      end else begin
        div_cnt <= base_tick ? '0 : div_cnt + PW'(1);
        if (base_tick) slot_ph <= slot_ph + 2'd1;
      end
    end
  end

  // Four strobe phases rotate, one per base phase pulse, each repeating every four base phases
  assign o_base_clock_phase = base_tick;
  assign o_strobe_phase_a   = base_tick && (slot_ph == 2'd0);
  assign o_strobe_phase_b   = base_tick && (slot_ph == 2'd1);
  assign o_strobe_phase_c   = base_tick && (slot_ph == 2'd2);
  assign o_strobe_phase_d   = base_tick && (slot_ph == 2'd3);

  // Mode capture during master clear
  logic [1:0] chan_legacy;
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      chan_legacy <= 2'b00;
    end else if (mc_active) begin
      chan_legacy <= ~i_chan_load_n;
    end
  end
  assign o_chan_legacy = chan_legacy;

  // Channel 1 input passes through a FIFO so bursts are not lost in level mode, unless a barrel writes mux register 1 on the same pulse
  logic       fifo_valid;
  cdms_word_t fifo_data;
  wire        fifo_pop = base_tick && !mc_active && !i_chan_load_n[1];
  cdms_fifo #(.WIDTH(`CDMS_DATA_W), .DEPTH(`CDMS_FIFO_DEPTH)) u_fifo (
    .i_core_clk  (i_core_clk),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (i_ext_valid1),
    .i_in_data   (i_ext_data1),
    .o_in_ready  (o_ext_ready1),
    .o_out_valid (fifo_valid),
    .o_out_data  (fifo_data),
    .i_out_ready (fifo_pop)
  );

  // Legacy buffer latched on strobe phase b
  cdms_word_t buf_reg [2];
  wire cdms_word_t ext_in [2];
  assign ext_in[0] = i_ext_data0;
  assign ext_in[1] = fifo_valid ? fifo_data : buf_reg[1];
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      buf_reg[0] <= `CDMS_MUX_RST;
      buf_reg[1] <= `CDMS_MUX_RST;
    end else if (o_strobe_phase_b) begin
      buf_reg[0] <= ext_in[0];
      buf_reg[1] <= ext_in[1];
    end
  end
  assign o_buffer_odd_parity = ~^buf_reg[1];

  // Mux registers
  cdms_word_t mux_reg [`CDMS_NUM_CH];
  cdms_word_t next_mux [`CDMS_NUM_CH];
  logic [`CDMS_NUM_CH-1:0] wr0;
  logic [`CDMS_NUM_CH-1:0] wr1;
  logic [`CDMS_NUM_CH-1:0] ext_ld;
  // Barrel 1 is chosen when both write, only reachable if the barrels misbehave
  assign wr0 = i_barrel0.fof & i_barrel0.sel;
  assign wr1 = i_barrel1.fof & i_barrel1.sel;

  always_comb begin
    for (int c = 0; c < `CDMS_NUM_CH; c++) begin
      ext_ld[c] = 1'b0;
      next_mux[c] = mux_reg[c];
      if (c < 2) begin
        ext_ld[c] = !mc_active && !i_chan_load_n[c] && !(wr0[c] || wr1[c]);
        // An empty FIFO in level mode holds the last word instead of a stale buffer
        if (ext_ld[c] && (c != 1 || chan_legacy[c] || fifo_valid)) begin
          next_mux[c] = chan_legacy[c] ? buf_reg[c] : ext_in[c];
        end
      end
      if (wr0[c]) next_mux[c] = i_barrel0.data;
      if (wr1[c]) next_mux[c] = i_barrel1.data;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int c = 0; c < `CDMS_NUM_CH; c++) mux_reg[c] <= `CDMS_MUX_RST;
    end else if (base_tick) begin
      for (int c = 0; c < `CDMS_NUM_CH; c++) mux_reg[c] <= next_mux[c];
    end
  end

  generate
    for (genvar g = 0; g < `CDMS_NUM_CH; g++) begin : g_par
      assign o_mux_register_odd_parity[g] = ~^mux_reg[g];
    end
  endgenerate

  // Read selection
  wire [`CDMS_NUM_CH-1:0] rd0 = i_barrel0.empty & i_barrel0.sel;
  wire [`CDMS_NUM_CH-1:0] rd1 = i_barrel1.empty & i_barrel1.sel;
  cdms_word_t rd_data0;
  cdms_word_t rd_data1;
  always_comb begin
    rd_data0 = '0;
    rd_data1 = '0;
    for (int c = 0; c < `CDMS_NUM_CH; c++) begin
      if (rd0[c]) rd_data0 = rd_data0 | mux_reg[c];
      if (rd1[c]) rd_data1 = rd_data1 | mux_reg[c];
    end
  end

  // Barrel outputs from flops updated every cycle, external outputs from flops held one phase
  cdms_word_t next_ext [2];
  assign next_ext[0] = chan_legacy[0] ? (o_strobe_phase_c ? mux_reg[0] : '0) : mux_reg[0];
  assign next_ext[1] = chan_legacy[1] ? (o_strobe_phase_c ? mux_reg[1] : '0) : mux_reg[1];
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_barrel0_data <= '0;
      o_barrel1_data <= '0;
      o_ext_out0     <= '0;
      o_ext_out1     <= '0;
    end else begin
      o_barrel0_data <= rd_data0;
      o_barrel1_data <= rd_data1;
      if (base_tick) begin
        o_ext_out0 <= next_ext[0];
        o_ext_out1 <= next_ext[1];
      end
    end
  end

  // Maintenance shifter: address picks channel, load snapshots flags
  logic [`CDMS_SHIFT_BITS-1:0] shreg;
  wire [1:0] mac_ch = (i_mac_addr == 2'd3) ? 2'd2 : i_mac_addr;
  wire cdms_ctl_s sel_ctl = i_chan_ctl[mac_ch];
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      shreg <= '0;
    end else if (i_mac_load) begin
      shreg <= sel_ctl;
    end else begin
      shreg <= {shreg[`CDMS_SHIFT_BITS-2:0], 1'b0};
    end
  end
  assign o_mac_serial_data = shreg[`CDMS_SHIFT_BITS-1];

  // Checks
  phase_sync_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    mcd_rise |=> (div_cnt == PW'(0)) && (slot_ph == 2'd0)) else $error("Phase not resynced");
  mode_hold_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    !mc_active && !$past(mc_active) |-> $stable(chan_legacy)) else $error("Mode changed");
  empty_low_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_barrel0.empty == '0) |=> (o_barrel0_data == '0)) else $error("Barrel 0 not zero");
  write_strobe_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    base_tick && wr0[0] && !wr1[0] |=> mux_reg[0] == $past(i_barrel0.data))
    else $error("Write lost");
  parity_odd_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    ^{o_mux_register_odd_parity[1], mux_reg[1]} == 1'b1) else $error("Parity wrong");
  buf_parity_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    ^{o_buffer_odd_parity, buf_reg[1]} == 1'b1) else $error("Buffer parity wrong");
  level_mirror_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    base_tick && !chan_legacy[0] |=> o_ext_out0 == $past(mux_reg[0])) else $error("No mirror");
  clear_noload_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    base_tick && mc_active && (wr0 | wr1) == '0 |=> $stable(mux_reg[0]))
    else $error("Load during clear");
  shift_out_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    i_mac_load && i_mac_addr == 2'd0 ##1 !i_mac_load |->
      o_mac_serial_data == $past(i_chan_ctl[0].active))
    else $error("Shift order");
endmodule : cdms_slice

// File: tb/cdms_ext_dev.sv
// External channel device model feeding channel 1 through valid/ready
`timescale 1ns/1ps
module cdms_ext_dev
  import cdms_pkg::*;
(
  // Clock
  input  wire logic i_core_clk,
  // Handshake to the slice
  input  wire logic i_ready,
  output logic      o_valid,
  output cdms_word_t o_data
);
  cdms_word_t q[$];
  bit         hs;

  initial begin
    o_valid = 1'b0;
    o_data  = 5'h00;
  end

  task automatic send(input cdms_word_t w);
    q.push_back(w);
  endtask : send

  // Word held until ready seen at an edge; idle data toggles so stale values never match
  always @(posedge i_core_clk) begin
    hs = o_valid && i_ready;
    #1;
    if (hs) begin
      void'(q.pop_front());
    end
    o_valid = (q.size() != 0);
    o_data  = o_valid ? q[0] : ~o_data;
  end
endmodule : cdms_ext_dev

// File: tb/channel_data_mux_slice_tb.sv
// Self-checking testbench for the channel data mux slice
`timescale 1ns/1ps
module channel_data_mux_slice_tb
  import cdms_pkg::*;
;
  logic         i_core_clk = 1'b0;
  logic         i_sys_rst  = 1'b1;
  logic         clr_n      = 1'b1;
  logic         mac_load   = 1'b0;
  logic [1:0]   load_n     = 2'h3;
  logic [1:0]   mac_addr   = 2'h0;
  cdms_barrel_s b0         = 14'h0000;
  cdms_barrel_s b1         = 14'h0000;
  cdms_word_t   ext0       = 5'h00;
  cdms_ctl_s [2:0] ctl     = 12'h000;
  cdms_word_t   data1, bd0, bd1, eo0, eo1;
  logic         valid1, ready1, bpar, mserial, basep;
  logic [2:0]   mpar;
  logic [1:0]   legacy;
  logic [3:0]   s;
  int           errors = 0;
  int           cmp_count = 0;
  int           n, k, j;

  always #5 i_core_clk = ~i_core_clk;

  cdms_slice u_dut (
    .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_master_clear_delayed_n(clr_n),
    .i_barrel0(b0), .i_barrel1(b1), .o_barrel0_data(bd0), .o_barrel1_data(bd1),
    .i_chan_load_n(load_n), .i_ext_data0(ext0), .i_ext_data1(data1),
    .i_ext_valid1(valid1), .o_ext_ready1(ready1), .o_ext_out0(eo0), .o_ext_out1(eo1),
    .o_buffer_odd_parity(bpar), .o_mux_register_odd_parity(mpar), .o_chan_legacy(legacy),
    .o_base_clock_phase(basep), .o_strobe_phase_a(), .o_strobe_phase_b(),
    .o_strobe_phase_c(), .o_strobe_phase_d(), .i_chan_ctl(ctl), .i_mac_addr(mac_addr),
    .i_mac_load(mac_load), .o_mac_serial_data(mserial));

  cdms_ext_dev u_dev (.i_core_clk(i_core_clk), .i_ready(ready1), .o_valid(valid1),
    .o_data(data1));

  task automatic stop_test();
    if (errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int c);
    repeat (c) @(posedge i_core_clk);
    #1;
  endtask : cyc

  // Bounded wait for the base phase pulse; n returns the cycles waited
  task automatic sync(output int w);
    for (w = 0; w < 10 && basep !== 1'b1; w++) cyc(1);
    if (w == 10) begin
      errors++;
      stop_test();
    end
  endtask : sync

  function automatic cdms_barrel_s bv(input logic [2:0] f, sl, e, input cdms_word_t d);
    return {f, sl, e, d};
  endfunction : bv

  // Barrel requests held across exactly one base phase, so one tick takes them
  task automatic drive(input cdms_barrel_s v0, input cdms_barrel_s v1);
    sync(n);
    b0 = v0;
    b1 = v1;
    cyc(5);
  endtask : drive

  initial begin
    repeat (4) @(posedge i_core_clk);
    #1 i_sys_rst = 1'b0;
    cyc(1);
    chk("mux_parity", 8'(mpar), 8'h07);
    chk("buffer_parity", 8'(bpar), 8'h01);
    chk("legacy", 8'(legacy), 8'h00);
    clr_n = 1'b0;
    load_n = 2'h2;
    cyc(10);
    clr_n = 1'b1;
    cyc(1);
    load_n = 2'h3;
    cyc(2);
    chk("legacy", 8'(legacy), 8'h01);
    sync(n);
    cyc(1);
    sync(n);
    chk("phase_gap", 8'(n), 8'h04);
    drive(bv(3'h2, 3'h2, 3'h0, 5'h15), bv(3'h4, 3'h4, 3'h0, 5'h19));
    drive(bv(3'h0, 3'h4, 3'h4, 5'h00), bv(3'h0, 3'h2, 3'h2, 5'h00));
    chk("b0_read", 8'(bd0), 8'h19);
    chk("b1_read", 8'(bd1), 8'h15);
    chk("par1", 8'(mpar[1]), 8'(~^5'h15));
    chk("par2", 8'(mpar[2]), 8'(~^5'h19));
    // Barrels write different registers, never the same one together
    drive(bv(3'h1, 3'h1, 3'h0, 5'h07), bv(3'h4, 3'h4, 3'h0, 5'h0E));
    chk("b0_no_empty", 8'(bd0), 8'h00);
    drive(bv(3'h0, 3'h4, 3'h4, 5'h00), 14'h0000);
    chk("b0_read", 8'(bd0), 8'h0E);
    for (k = 0; k < 5; k++) u_dev.send(5'(5'h01 + k));
    cyc(10);
    chk("fifo_full", 8'(ready1), 8'h00);
    load_n = 2'h1;
    cyc(35);
    load_n = 2'h3;
    cyc(5);
    chk("fifo_drained", 8'(ready1), 8'h01);
    chk("ext_out1", 8'(eo1), 8'h05);
    drive(14'h0000, bv(3'h0, 3'h2, 3'h2, 5'h00));
    chk("b1_level", 8'(bd1), 8'h05);
    ext0 = 5'h0B;
    load_n = 2'h2;
    cyc(45);
    load_n = 2'h3;
    sync(n);
    n = 0;
    repeat (20) begin
      cyc(1);
      if (eo0 === 5'h0B) n++;
      else if (eo0 !== 5'h00) n = 99;
    end
    chk("ext_out0_pulse", 8'(n), 8'h05);
    drive(bv(3'h0, 3'h1, 3'h1, 5'h00), 14'h0000);
    chk("b0_legacy", 8'(bd0), 8'h0B);
    chk("par0", 8'(mpar[0]), 8'(~^5'h0B));
    ctl = 12'h5A3;
    for (k = 0; k < 4; k++) begin
      mac_addr = 2'(k);
      mac_load = 1'b1;
      cyc(1);
      mac_load = 1'b0;
      for (j = 0; j < 4; j++) begin
        s[3-j] = mserial;
        cyc(1);
      end
      chk("mac_bits", 8'(s), 8'(ctl[(k == 3) ? 2 : k]));
    end
    stop_test();
  end
endmodule : channel_data_mux_slice_tb
